// ### rtl/nbseq_core.sv
`timescale 1ns/1ps
`include "nbseq_defs.svh"

module nbseq_core (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial link
    input  wire logic        si,
    output logic             so,
    output logic             serial_clock_output,
    // l port
    output logic      [7:0]  l_o,
    output logic             l_oe
);

    logic [7:0]           rom_mem [0:511];
    logic [8:0]           rom_addr_ff;
    nbseq_pkg::nbseq_ctrl_t  ctrl_ff;
    nbseq_pkg::nbseq_opt_t   opt_ff;
    nbseq_pkg::nbseq_stack_t stk_ff;
    nbseq_pkg::nbseq_state_t state_ff;
    logic [8:0]           program_counter_ff;
    logic [8:0]           ind_ff;
    logic                 lq_ff;
    logic                 skip_ff;
    logic [3:0]           acc_ff;
    logic [3:0]           mem_ff;
    logic [3:0]           serial_shift_count_reg_ff;
    logic                 carry_ff;
    logic                 skl_ff;
    logic                 si_prev_ff;
    logic [7:0]           q_ff;
    logic [7:0]           lout_ff;
    logic [3:0]           div_ff;
    logic [31:0]          prdata_ff;
    logic                 pready_ff;
    logic                 pslverr_ff;
    logic                 so_ff;
    logic                 sclk_ff;
    logic [7:0]           l_o_ff;
    logic                 l_oe_ff;

    logic [3:0]  div_max;
    logic        tick;
    logic        running;
    logic        step;
    logic        exec;
    logic [7:0]  op;
    logic [8:0]  pc_inc;
    logic [8:0]  ind_addr;
    logic        is_sjump;
    logic        is_pcall;
    logic        wr_en;
    logic        rd_setup;
    logic [31:0] rdata;
    logic        mapped;

    // instruction cycle divider
    always_comb begin
        case (opt_ff.osc_sel)
            `NBSEQ_OSC_XT8, `NBSEQ_OSC_EXT8:   div_max = `NBSEQ_DIV8_MAX;
            `NBSEQ_OSC_XT16, `NBSEQ_OSC_EXT16: div_max = `NBSEQ_DIV16_MAX;
            default:                           div_max = `NBSEQ_DIV4_MAX;
        endcase
    end

    assign tick    = (div_ff == div_max);
    // without init logic the core waits for software to set run
    assign running = ctrl_ff.run | ~opt_ff.init_absent;
    assign step    = running & tick;
    assign exec    = step & (state_ff == nbseq_pkg::ST_FETCH) & ~skip_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= `NBSEQ_RST_DIV;
        end else if (tick) begin
            div_ff <= `NBSEQ_RST_DIV;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    // fetch and decode
    assign op       = rom_mem[program_counter_ff];
    assign pc_inc   = program_counter_ff + 9'h001;
    // incremented pc supplies the page, so last-word ops see the next page
    assign ind_addr = {pc_inc[8], acc_ff, mem_ff};
    assign is_sjump = (op[7:6] == `NBSEQ_OP_SJMP) && (op != `NBSEQ_OP_JIND);
    assign is_pcall = (op[7:6] == `NBSEQ_OP_PCALL) && (op != `NBSEQ_OP_TBL);

    // sequencer: pc, stack, skip, indirect phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_ff <= `NBSEQ_RST_PC;
            stk_ff             <= '0;
            state_ff           <= nbseq_pkg::ST_FETCH;
            ind_ff             <= `NBSEQ_RST_PC;
            lq_ff              <= 1'b0;
            skip_ff            <= 1'b0;
            q_ff               <= `NBSEQ_RST_BYTE;
        end else if (step) begin
            case (state_ff)
                nbseq_pkg::ST_FETCH: begin
                    program_counter_ff <= pc_inc;
                    skip_ff            <= 1'b0;
                    if (!skip_ff) begin
                        if (op == `NBSEQ_OP_SKZ) begin
                            skip_ff <= (acc_ff == `NBSEQ_RST_NIB);
                        end else if (op == `NBSEQ_OP_JIND) begin
                            ind_ff   <= ind_addr;
                            lq_ff    <= 1'b0;
                            state_ff <= nbseq_pkg::ST_IND;
                        end else if (op == `NBSEQ_OP_TBL) begin
                            stk_ff             <= {pc_inc, stk_ff.lvl1};
                            program_counter_ff <= ind_addr;
                            lq_ff              <= 1'b1;
                            state_ff           <= nbseq_pkg::ST_IND;
                        end else if (is_sjump) begin
                            program_counter_ff <= {pc_inc[8:6], op[5:0]};
                        end else if (is_pcall) begin
                            stk_ff             <= {pc_inc, stk_ff.lvl1};
                            program_counter_ff <= {`NBSEQ_PAGE2, op[5:0]};
                        end else if (op == `NBSEQ_OP_RET) begin
                            program_counter_ff <= stk_ff.lvl1;
                            stk_ff.lvl1        <= stk_ff.lvl2;
                        end
                    end
                end
                nbseq_pkg::ST_IND: begin
                    state_ff <= nbseq_pkg::ST_FETCH;
                    if (lq_ff) begin
                        q_ff               <= op;
                        program_counter_ff <= stk_ff.lvl1;
                        stk_ff.lvl1        <= stk_ff.lvl2;
                    end else begin
                        program_counter_ff <= {program_counter_ff[8],
                                               rom_mem[ind_ff]};
                    end
                end
                default: state_ff <= nbseq_pkg::ST_FETCH;
            endcase
        end
    end

    // accumulator and carry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff   <= `NBSEQ_RST_NIB;
            carry_ff <= 1'b0;
        end else if (exec) begin
            if (op == `NBSEQ_OP_CLR_ACC) begin
                acc_ff <= `NBSEQ_RST_NIB;
            end else if (op[7:4] == `NBSEQ_OP_LDI) begin
                acc_ff <= op[3:0];
            end else if (op == `NBSEQ_OP_SWAP) begin
                acc_ff <= serial_shift_count_reg_ff;
            end else if (op == `NBSEQ_OP_SC) begin
                carry_ff <= 1'b1;
            end else if (op == `NBSEQ_OP_RC) begin
                carry_ff <= 1'b0;
            end
        end else if (wr_en && !running && paddr == `NBSEQ_A_ACC) begin
            // software may preload only while the core is stopped
            acc_ff <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ff <= `NBSEQ_RST_NIB;
        end else if (wr_en && paddr == `NBSEQ_A_MEM) begin
            mem_ff <= pwdata[3:0];
        end
    end

    // serial register: shift once per instruction cycle, or count rising si edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_shift_count_reg_ff <= `NBSEQ_RST_NIB;
            // idle line level, so count mode sees no false edge after reset
            si_prev_ff                <= 1'b1;
            skl_ff                    <= 1'b0;
        end else begin
            si_prev_ff <= si;
            if (exec && op == `NBSEQ_OP_SWAP) begin
                serial_shift_count_reg_ff <= acc_ff;
                skl_ff                    <= carry_ff;
            end else if (ctrl_ff.cnt_mode) begin
                if (si && !si_prev_ff) begin
                    serial_shift_count_reg_ff <=
                        serial_shift_count_reg_ff + 4'h1;
                end
            end else if (running && tick) begin
                serial_shift_count_reg_ff <=
                    {serial_shift_count_reg_ff[2:0], si};
            end
        end
    end

    // pins; in shift mode, while skl_ff is set, the clock pulses in the first half of each cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_ff   <= 1'b0;
            sclk_ff <= 1'b0;
            l_o_ff  <= `NBSEQ_RST_BYTE;
            l_oe_ff <= 1'b0;
        end else begin
            so_ff   <= ~ctrl_ff.cnt_mode & serial_shift_count_reg_ff[3];
            sclk_ff <= ctrl_ff.cnt_mode ? skl_ff :
                       (skl_ff & (div_ff <= (div_max >> 1)));
            l_o_ff  <= lout_ff;
            l_oe_ff <= ctrl_ff.l_drive;
        end
    end

    // program rom load port, auto-incrementing address
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == `NBSEQ_A_ROMD) begin
            rom_mem[rom_addr_ff] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_addr_ff <= `NBSEQ_RST_PC;
        end else if (wr_en && paddr == `NBSEQ_A_ROMA) begin
            rom_addr_ff <= pwdata[8:0];
        end else if (wr_en && paddr == `NBSEQ_A_ROMD) begin
            rom_addr_ff <= rom_addr_ff + 9'h001;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            opt_ff  <= '0;
            lout_ff <= `NBSEQ_RST_BYTE;
        end else if (wr_en) begin
            if (paddr == `NBSEQ_A_CTRL) begin
                ctrl_ff <= pwdata[2:0];
            end else if (paddr == `NBSEQ_A_OPT) begin
                opt_ff <= pwdata[3:0];
            end else if (paddr == `NBSEQ_A_LOUT) begin
                lout_ff <= pwdata[7:0];
            end
        end
    end

    // apb: one wait state, so every answer comes from a flop
    assign wr_en    = psel & penable & pready_ff & pwrite;
    assign rd_setup = psel & penable & ~pready_ff;

    always_comb begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == `NBSEQ_A_CTRL) begin
            rdata[2:0] = ctrl_ff;
        end else if (paddr == `NBSEQ_A_OPT) begin
            rdata[3:0] = opt_ff;
        end else if (paddr == `NBSEQ_A_ACC) begin
            rdata[3:0] = acc_ff;
        end else if (paddr == `NBSEQ_A_MEM) begin
            rdata[3:0] = mem_ff;
        end else if (paddr == `NBSEQ_A_SER) begin
            rdata[3:0] = serial_shift_count_reg_ff;
        end else if (paddr == `NBSEQ_A_PC) begin
            rdata[8:0] = program_counter_ff;
        end else if (paddr == `NBSEQ_A_Q) begin
            rdata[7:0] = q_ff;
        end else if (paddr == `NBSEQ_A_STACK) begin
            rdata[17:0] = stk_ff;
        end else if (paddr == `NBSEQ_A_ROMA) begin
            rdata[8:0] = rom_addr_ff;
        end else if (paddr == `NBSEQ_A_ROMD) begin
            rdata[7:0] = rom_mem[rom_addr_ff];
        end else if (paddr == `NBSEQ_A_LOUT) begin
            rdata[7:0] = lout_ff;
        end else if (paddr == `NBSEQ_A_STAT) begin
            rdata[4:0] = {carry_ff, lq_ff, skip_ff, running,
                          state_ff == nbseq_pkg::ST_IND};
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= rd_setup;
            pslverr_ff <= rd_setup & ~mapped;
            if (rd_setup && !pwrite) begin
                prdata_ff <= rdata;
            end
        end
    end

    assign prdata              = prdata_ff;
    assign pready              = pready_ff;
    assign pslverr             = pslverr_ff;
    assign so                  = so_ff;
    assign serial_clock_output = sclk_ff;
    assign l_o                 = l_o_ff;
    assign l_oe                = l_oe_ff;

endmodule : nbseq_core

// ### rtl/nbseq_defs.svh
`ifndef NBSEQ_DEFS_SVH
`define NBSEQ_DEFS_SVH

// register byte offsets
`define NBSEQ_A_CTRL   8'h00
`define NBSEQ_A_OPT    8'h04
`define NBSEQ_A_ACC    8'h08
`define NBSEQ_A_MEM    8'h0c
`define NBSEQ_A_SER    8'h10
`define NBSEQ_A_PC     8'h14
`define NBSEQ_A_Q      8'h18
`define NBSEQ_A_STACK  8'h1c
`define NBSEQ_A_ROMA   8'h20
`define NBSEQ_A_ROMD   8'h24
`define NBSEQ_A_LOUT   8'h28
`define NBSEQ_A_STAT   8'h2c

// reset values
`define NBSEQ_RST_PC   9'h000
`define NBSEQ_RST_NIB  4'h0
`define NBSEQ_RST_BYTE 8'h00
`define NBSEQ_RST_DIV  4'h0

// opcodes
`define NBSEQ_OP_CLR_ACC 8'h00
`define NBSEQ_OP_SWAP  8'h4f
`define NBSEQ_OP_JIND  8'hff
`define NBSEQ_OP_TBL   8'hbf
`define NBSEQ_OP_RET   8'h48
`define NBSEQ_OP_SKZ   8'h20
`define NBSEQ_OP_SC    8'h22
`define NBSEQ_OP_RC    8'h32
`define NBSEQ_OP_LDI   4'h7
`define NBSEQ_OP_SJMP  2'h3
`define NBSEQ_OP_PCALL 2'h2

// page-two base for the page call
`define NBSEQ_PAGE2    3'h2

// instruction cycle length minus one, per oscillator option
`define NBSEQ_DIV4_MAX  4'h3
`define NBSEQ_DIV8_MAX  4'h7
`define NBSEQ_DIV16_MAX 4'hf
`define NBSEQ_OSC_XT4   3'h0
`define NBSEQ_OSC_RC4   3'h1
`define NBSEQ_OSC_EXT4  3'h2
`define NBSEQ_OSC_XT8   3'h3
`define NBSEQ_OSC_EXT8  3'h4
`define NBSEQ_OSC_XT16  3'h5
`define NBSEQ_OSC_EXT16 3'h6

`endif

// ### rtl/nbseq_pkg.sv
package nbseq_pkg;

    typedef enum logic {ST_FETCH, ST_IND} nbseq_state_t;

    typedef struct packed {
        logic l_drive;
        logic cnt_mode;
        logic run;
    } nbseq_ctrl_t;

    typedef struct packed {
        logic       init_absent;
        logic [2:0] osc_sel;
    } nbseq_opt_t;

    typedef struct packed {
        logic [8:0] lvl1;
        logic [8:0] lvl2;
    } nbseq_stack_t;

endpackage : nbseq_pkg

// ### tb/nbseq_core_chk.sv
`timescale 1ns/1ps
module nbseq_core_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // serial link and l port
    input wire logic        si,
    input wire logic        so,
    input wire logic        serial_clock_output,
    input wire logic [7:0]  l_o,
    input wire logic        l_oe
);
    logic cnt_ff;
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    // mirror of the mode bit, taken only at a committed write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 1'b0;
        end else if (wr && paddr == 8'h00) begin
            cnt_ff <= pwdata[1];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_rdy_late;
        s_setup ##1 s_access |-> !pready ##1 pready;
    endproperty
    a_rdy_late: assert property (p_rdy_late)
        else $error("pready not in second access cycle");
    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("pready longer than one cycle");
    property p_err_rdy;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_rdy: assert property (p_err_rdy)
        else $error("pslverr outside a completing access");
    property p_err_map;
        pready && paddr > 8'h2c |-> pslverr;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("unmapped address not refused");
    property p_ok_map;
        pready && paddr <= 8'h2c && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_ok_map: assert property (p_ok_map)
        else $error("mapped address refused");
    property p_rst_quiet;
        $rose(presetn) |-> !so && !serial_clock_output && !l_oe && l_o == 8'h00;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    property p_oe;
        wr && paddr == 8'h00 |-> ##2 l_oe == $past(pwdata[2], 2);
    endproperty
    a_oe: assert property (p_oe)
        else $error("l_oe does not follow drive bit");
    property p_lo;
        wr && paddr == 8'h28 |-> ##2 l_o == $past(pwdata[7:0], 2);
    endproperty
    a_lo: assert property (p_lo)
        else $error("l_o does not follow written data");
    property p_so_cnt;
        cnt_ff && $past(cnt_ff) |-> !so;
    endproperty
    a_so_cnt: assert property (p_so_cnt)
        else $error("so active in count mode");
endmodule : nbseq_core_chk

// ### tb/nbseq_serial_peer.sv
`timescale 1ns/1ps
// far-side serial source: steady high, or a square wave of 16 pclk
module nbseq_serial_peer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control and line
    input wire logic toggle,
    output logic     si
);
    logic [2:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 3'h0;
            si     <= 1'b1;
        end else if (!toggle) begin
            si <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
                si <= !si;
            end
        end
    end
endmodule : nbseq_serial_peer

// ### tb/tb_nbseq_core.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    fails++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tb_nbseq_core;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, l_o;
    logic [31:0] pwdata, prdata, r, s0;
    logic        si, so, sck, l_oe, toggle, e;
    int          fails, samples_checked;
    // program first, then table data, then the code at the jump targets; M stays 0 after reset
    logic [15:0] rom_tbl [9] = '{16'h0000, 16'h0173, 16'h02bf,
        16'h034f, 16'h04ff, 16'h30a6, 16'hf03f, 16'h3fc8, 16'h48c8};

    nbseq_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .si(si),
        .so(so), .serial_clock_output(sck), .l_o(l_o), .l_oe(l_oe));
    nbseq_serial_peer peer (.pclk(pclk), .presetn(presetn),
        .toggle(toggle), .si(si));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed latency: only the watchdog ends a wait that hangs
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        err;
        apb(1'b1, a, d, q, err);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic err;
        apb(1'b0, a, 32'h0, q, err);
    endtask : rd

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; toggle = 1'b0;
        fails = 0; samples_checked = 0;
        do_reset();
        // halt the core before the rom holds a program
        wr(8'h04, 32'h8);
        rd(8'h04, r);
        `CHK("opt", 32'h8, r)
        wr(8'h04, 32'hd);
        rd(8'h04, r);
        `CHK("opt div16", 32'hd, r)
        apb(1'b1, 8'h30, 32'h1, r, e);
        `CHK("unmapped", 1'b1, e)
        foreach (rom_tbl[i]) begin
            wr(8'h20, {24'h0, rom_tbl[i][15:8]});
            wr(8'h24, {24'h0, rom_tbl[i][7:0]});
        end
        wr(8'h20, 32'h30);
        rd(8'h24, r);
        `CHK("rom readback", 32'ha6, r)
        $display("test registers done");
        // rom survives reset; init logic then starts the program at 0
        do_reset();
        wr(8'h00, 32'h4);
        wr(8'h28, 32'h5a);
        repeat (100) @(posedge pclk);
        rd(8'h18, r);
        `CHK("table byte", 32'ha6, r)
        rd(8'h08, r);
        `CHK("acc after swap", 32'hf, r)
        rd(8'h14, r);
        `CHK("pc page", 6'h09, r[8:3])
        rd(8'h1c, r);
        `CHK("stack popped", 32'h0, r)
        rd(8'h10, r);
        `CHK("serial shifted", 32'hf, r)
        // pins are looked at away from the edge that launches them
        @(negedge pclk);
        `CHK("so shift", 1'b1, so)
        `CHK("l port", 8'h5a, l_o)
        `CHK("l enable", 1'b1, l_oe)
        $display("test program done");
        wr(8'h00, 32'h2);
        toggle <= 1'b1;
        rd(8'h10, s0);
        repeat (64) @(posedge pclk);
        rd(8'h10, r);
        r = (r - s0) & 32'hf;
        `CHK("count step", 1'b1, r == 32'h4 || r == 32'h5)
        @(negedge pclk);
        `CHK("l off", 1'b0, l_oe)
        $display("test counter done");
        stop_test();
    end
endmodule : tb_nbseq_core

bind nbseq_core nbseq_core_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .si(si), .so(so), .serial_clock_output(serial_clock_output),
    .l_o(l_o), .l_oe(l_oe));
